// [shared/tbpwm_pkg.sv]
// Package for the ten-bit PWM block: register map, fields, reset values
// and the structs that carry the time base and register traffic.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package tbpwm_pkg;

  localparam int TB_CH_N = 2;

  // Byte offsets on the register bus
  localparam logic [7:0] OFS_TCTL   = 8'h00;
  localparam logic [7:0] OFS_PER    = 8'h04;
  localparam logic [7:0] OFS_CNT    = 8'h08;
  localparam logic [7:0] OFS_CH0    = 8'h10;
  localparam logic [3:0] OFS_CH_CTL = 4'h0;
  localparam logic [3:0] OFS_CH_DH  = 4'h4;
  localparam logic [3:0] OFS_CH_DL  = 4'h8;
  localparam logic [3:0] OFS_CH_DIR = 4'hc;
  localparam int         CH_SHIFT   = 4;

  // Base timer control fields
  localparam int TCTL_ON_B   = 7;
  localparam int TCTL_CKPS_H = 6;
  localparam int TCTL_CKPS_L = 4;
  localparam int TCTL_OUTP_H = 3;
  localparam int TCTL_OUTP_L = 0;

  // Channel control fields
  localparam int CTL_EN_B  = 7;
  localparam int CTL_OUT_B = 5;
  localparam int CTL_POL_B = 4;
  localparam int DL_H      = 7;
  localparam int DL_L      = 6;
  localparam int DIR_B     = 0;

  // Reset values
  localparam logic [7:0] PER_RST  = 8'hff;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic       DIR_RST  = 1'b1;

  localparam logic [1:0] SUB_MAX  = 2'h3;

  typedef struct packed {
    logic       start;
    logic       run;
    logic [9:0] tb;
  } tbpwm_tbase_t;

  typedef struct packed {
    logic       ctl;
    logic       dh;
    logic       dl;
    logic       dir;
    logic [7:0] data;
  } tbpwm_wr_t;

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] dh;
    logic [7:0] dl;
    logic [7:0] dir;
  } tbpwm_rd_t;

endpackage

// [rtl/tbpwm_chan.sv]
// One PWM channel: control, duty registers, duty buffer and output.
// Assumes the shared time base and write strobes from tbpwm_top.
`timescale 1ns/1ps
module tbpwm_chan
  import tbpwm_pkg::*;
(
  input  wire logic         i_mclk,
  input  wire logic         i_rst_b,
  input  wire tbpwm_tbase_t i_tbase,
  input  wire tbpwm_wr_t    i_wr,
  output tbpwm_rd_t         o_rd,
  output logic              o_wave,
  output logic              o_pin_oe_b
);

  typedef struct packed {
    logic       en;
    logic       pol;
    logic       dir;
    logic [7:0] dh;
    logic [1:0] dl;
    logic [9:0] buf_duty;
    logic       out;
    logic       lvl;
  } tbpwm_ch_st_t;

  tbpwm_ch_st_t st_r;
  tbpwm_ch_st_t st_nxt;
  logic [9:0]   duty_new;

  always_comb begin
    st_nxt   = st_r;
    duty_new = {st_r.dh, st_r.dl};
    // Writes land any time; the running period uses the buffer
    if (i_wr.ctl) begin
      st_nxt.en  = i_wr.data[CTL_EN_B];
      st_nxt.pol = i_wr.data[CTL_POL_B];
    end
    if (i_wr.dh) begin
      st_nxt.dh = i_wr.data;
    end
    if (i_wr.dl) begin
      st_nxt.dl = i_wr.data[DL_H:DL_L];
    end
    if (i_wr.dir) begin
      st_nxt.dir = i_wr.data[DIR_B];
    end
    if (!st_r.en) begin
      st_nxt.out = 1'b0;
    end else if (i_tbase.start) begin
      st_nxt.buf_duty = duty_new;
      st_nxt.out      = (duty_new != '0);
    end else if (i_tbase.run && i_tbase.tb == st_r.buf_duty) begin
      // Duty beyond the period never matches, so output stays set
      st_nxt.out = 1'b0;
    end
    st_nxt.lvl = st_nxt.out ^ st_nxt.pol;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r          <= '0;
      st_r.dh       <= DUTY_RST;
      st_r.dir      <= DIR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_wave     = st_r.lvl;
  assign o_pin_oe_b = st_r.dir;

  always_comb begin
    o_rd                = '0;
    o_rd.ctl[CTL_EN_B]  = st_r.en;
    o_rd.ctl[CTL_OUT_B] = st_r.lvl;
    o_rd.ctl[CTL_POL_B] = st_r.pol;
    o_rd.dh             = st_r.dh;
    o_rd.dl[DL_H:DL_L]  = st_r.dl;
    o_rd.dir[DIR_B]     = st_r.dir;
  end

endmodule

// [rtl/tbpwm_top.sv]
// Ten-bit PWM block: shared base timer, register slave, channels.
// Assumes an Avalon-MM master with waitrequest on i_mclk, and a sleep
// request from power control already synchronous to i_mclk.
//
// Functional notes
// - Each channel makes a ten-bit PWM whose period comes from the base timer.
// - All channels share one period; each has its own duty value.
// - The postscaler setting never affects the waveform.
// - Output goes active when the base timer count clears to zero.
// - Output goes inactive when the time base equals the duty value.
// - Duty at or past the period end never clears: full duty.
// - Duty registers are buffered, loaded only at the period match.
// - Polarity bit inverts the output waveform.
// - Period is (limit plus one) times four clocks times prescale.
// - After a match: clear count, set output unless duty zero, load buffer.
// - Duty registers accept writes any time without disturbing the waveform.
// - Pulse width is duty times one clock times prescale.
// - Time base is count with two low bits from clock or prescaler.
// - Resolution is log2 of four times (limit plus one).
// - Pulse width beyond the period leaves the output level unchanged.
// - In sleep the timer and channels freeze, output holds its level.
// - Polarity clear means active high; set means active low.
// - Control register shows the current output level, read only.
// - Reset restores registers and turns pins into inputs.
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module tbpwm_top
  import tbpwm_pkg::*;
#(
  parameter int N_CH = TB_CH_N
)
(
  input  wire logic            i_mclk,
  input  wire logic            i_rst_b,
  input  wire logic [7:0]      i_avs_address,
  input  wire logic            i_avs_read,
  input  wire logic            i_avs_write,
  input  wire logic [31:0]     i_avs_writedata,
  input  wire logic [3:0]      i_avs_byteenable,
  output logic      [31:0]     o_avs_readdata,
  output logic                 o_avs_waitrequest,
  input  wire logic            i_sleep,
  output logic      [N_CH-1:0] o_wave,
  output logic      [N_CH-1:0] o_pin_out,
  output logic      [N_CH-1:0] o_pin_oe_b
);

  typedef struct packed {
    logic        on;
    logic [2:0]  ckps;
    logic [3:0]  outps;
    logic [7:0]  per;
    logic [7:0]  cnt;
    logic [6:0]  pre;
    logic [1:0]  sub;
    logic        ack;
    logic [31:0] rdata;
  } tbpwm_top_st_t;

  tbpwm_top_st_t st_r;
  tbpwm_top_st_t st_nxt;

  tbpwm_tbase_t  tbase;
  tbpwm_wr_t     ch_wr [N_CH];
  tbpwm_rd_t     ch_rd [N_CH];

  logic          req;
  logic          done;
  logic          wr_ok;
  logic [6:0]    pre_top;
  logic          run;
  logic          ptick;
  logic          inc;
  logic          start;
  logic [7:0]    ch_off;
  logic [3:0]    ch_sub;
  logic [7:0]    ch_idx;
  logic          ch_hit;
  logic [7:0]    rd_byte;
  logic [7:0]    tctl_rd;

  // One wait cycle per access; read data is captured in the first
  // cycle so it stands registered when waitrequest drops.
  assign req   = i_avs_read | i_avs_write;
  assign done  = req & st_r.ack;
  assign wr_ok = i_avs_write & done & i_avs_byteenable[0];

  assign o_avs_waitrequest = req & ~st_r.ack;
  assign o_avs_readdata    = st_r.rdata;

  // Channel window decode
  assign ch_off = i_avs_address - OFS_CH0;
  assign ch_sub = ch_off[CH_SHIFT-1:0];
  assign ch_idx = ch_off >> CH_SHIFT;
  assign ch_hit = (i_avs_address >= OFS_CH0) &&
                  (ch_idx < 8'(N_CH));

  // Prescaler: ratio is two to the power of the select field
  assign pre_top = 7'((8'h01 << st_r.ckps) - 8'h01);
  assign run     = st_r.on & ~i_sleep;
  assign ptick   = run & (st_r.pre == pre_top);
  assign inc     = ptick & (st_r.sub == SUB_MAX);
  assign start   = inc & (st_r.cnt == st_r.per);

  // Postscaler field is stored and read back only
  always_comb begin
    tctl_rd                          = '0;
    tctl_rd[TCTL_ON_B]               = st_r.on;
    tctl_rd[TCTL_CKPS_H:TCTL_CKPS_L] = st_r.ckps;
    tctl_rd[TCTL_OUTP_H:TCTL_OUTP_L] = st_r.outps;
  end

  always_comb begin
    rd_byte = '0;
    if (ch_hit) begin
      for (int c = 0; c < N_CH; c++) begin
        if (ch_idx == 8'(c)) begin
          case (ch_sub)
            OFS_CH_CTL: rd_byte = ch_rd[c].ctl;
            OFS_CH_DH:  rd_byte = ch_rd[c].dh;
            OFS_CH_DL:  rd_byte = ch_rd[c].dl;
            OFS_CH_DIR: rd_byte = ch_rd[c].dir;
            default:    rd_byte = '0;
          endcase
        end
      end
    end else begin
      case (i_avs_address)
        OFS_TCTL: rd_byte = tctl_rd;
        OFS_PER:  rd_byte = st_r.per;
        OFS_CNT:  rd_byte = st_r.cnt;
        default:  rd_byte = '0;
      endcase
    end
  end

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack) begin
      st_nxt.rdata = {24'h000000, rd_byte};
    end

    // Base timer: frozen while off or asleep
    if (run) begin
      st_nxt.pre = ptick ? 7'h00 : 7'(st_r.pre + 7'h01);
    end
    if (ptick) begin
      st_nxt.sub = 2'(st_r.sub + 2'h1);
    end
    if (inc) begin
      // Shared count gives every channel the same period
      st_nxt.cnt = start ? 8'h00 : 8'(st_r.cnt + 8'h01);
    end

    if (wr_ok) begin
      case (i_avs_address)
        OFS_TCTL: begin
          st_nxt.on    = i_avs_writedata[TCTL_ON_B];
          st_nxt.ckps  = i_avs_writedata[TCTL_CKPS_H:TCTL_CKPS_L];
          st_nxt.outps = i_avs_writedata[TCTL_OUTP_H:TCTL_OUTP_L];
          // New ratio may sit below the old prescale count
          st_nxt.pre   = '0;
        end
        OFS_PER: begin
          st_nxt.per = i_avs_writedata[7:0];
        end
        OFS_CNT: begin
          st_nxt.cnt = i_avs_writedata[7:0];
          st_nxt.pre = '0;
          st_nxt.sub = '0;
        end
        default: begin
          st_nxt.cnt = st_nxt.cnt;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r     <= '0;
      st_r.per <= PER_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Ten-bit time base shared by all channels
  always_comb begin
    tbase       = '0;
    tbase.start = start;
    // Qualifier is the tick, and tb is the value the tick moves to, so the
    // output drops as the time base reaches the duty value, not one later
    tbase.run   = ptick;
    tbase.tb    = 10'({st_r.cnt, st_r.sub} + 10'h001);
  end

  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    always_comb begin
      ch_wr[g]      = '0;
      ch_wr[g].data = i_avs_writedata[7:0];
      if (wr_ok && ch_hit && ch_idx == 8'(g)) begin
        ch_wr[g].ctl = (ch_sub == OFS_CH_CTL);
        ch_wr[g].dh  = (ch_sub == OFS_CH_DH);
        ch_wr[g].dl  = (ch_sub == OFS_CH_DL);
        ch_wr[g].dir = (ch_sub == OFS_CH_DIR);
      end
    end

    tbpwm_chan u_chan (
      .i_mclk     (i_mclk),
      .i_rst_b    (i_rst_b),
      .i_tbase    (tbase),
      .i_wr       (ch_wr[g]),
      .o_rd       (ch_rd[g]),
      .o_wave     (o_wave[g]),
      .o_pin_oe_b (o_pin_oe_b[g])
    );

    // Pin carries the wave whatever its direction setting
    assign o_pin_out[g] = o_wave[g];
  end

endmodule

// [tb/tbpwm_sink.sv]
// Pin-side sink for one PWM output: measures active time and period.
// Assumes a level that only changes just after rising clock edges.
`timescale 1ns/1ps
module tbpwm_sink (
  input  wire logic        i_mclk,
  input  wire logic        i_lvl,
  output logic      [15:0] o_hi,
  output logic      [15:0] o_per
);
  logic [15:0] cnt_r = 16'h0;
  logic        lvl_r = 1'b0;
  always @(posedge i_mclk) begin
    lvl_r <= i_lvl;
    cnt_r <= (i_lvl && !lvl_r) ? 16'h1 : cnt_r + 16'h1;
    if (i_lvl && !lvl_r) o_per <= cnt_r;
    if (!i_lvl && lvl_r) o_hi <= cnt_r;
  end
endmodule

// [tb/tbpwm_chk.sv]
// Port-level assertions for tbpwm_top, bound in below.
// Assumes one clock domain and the one-wait bus slave of the note.
`timescale 1ns/1ps
module tbpwm_chk
  import tbpwm_pkg::*;
#(
  parameter int N_CH = TB_CH_N
)
(
  input wire logic            i_mclk,
  input wire logic            i_rst_b,
  input wire logic [7:0]      i_avs_address,
  input wire logic            i_avs_read,
  input wire logic            i_avs_write,
  input wire logic [31:0]     o_avs_readdata,
  input wire logic            o_avs_waitrequest,
  input wire logic            i_sleep,
  input wire logic [N_CH-1:0] o_wave,
  input wire logic [N_CH-1:0] o_pin_out,
  input wire logic [N_CH-1:0] o_pin_oe_b
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic rd_done;
  assign rd_done = i_avs_read && !o_avs_waitrequest;
  pin_mirror_a: assert property (
    o_pin_out == o_wave) else $error("pin value differs from wave");
  sleep_hold_a: assert property (
    i_sleep && !i_avs_write |=> $stable(o_wave))
    else $error("wave moved in sleep");
  dir_hold_a: assert property (
    !i_avs_write |=> $stable(o_pin_oe_b))
    else $error("pin enable moved without write");
  one_wait_a: assert property (
    $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest
      ##1 !o_avs_waitrequest) else $error("wait cycle count wrong");
  level_read_a: assert property (
    rd_done && i_avs_address == OFS_CH0 |->
      o_avs_readdata[CTL_OUT_B] == $past(o_wave[0]))
    else $error("level bit differs from wave");
  high_zero_a: assert property (
    rd_done |-> o_avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  dl_unused_a: assert property (
    rd_done && i_avs_address == OFS_CH0 + 8'h08 |->
      o_avs_readdata[5:0] == 6'h0) else $error("duty low spare bits set");
  wave_rst_a: assert property (
    $rose(i_rst_b) |-> o_wave == '0) else $error("wave not idle at reset");
  pin_rst_a: assert property (
    $rose(i_rst_b) |-> &o_pin_oe_b) else $error("pin driven at reset");
endmodule
bind tbpwm_top tbpwm_chk #(.N_CH(N_CH)) tbpwm_chk_inst (.i_mclk, .i_rst_b,
  .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
  .o_avs_waitrequest, .i_sleep, .o_wave, .o_pin_out, .o_pin_oe_b);

// [tb/ten_bit_pwm_channel_bench.sv]
// Bench for tbpwm_top: bus tasks, waveform scenarios and verdict.
// Assumes tbpwm_chk is bound in and one tbpwm_sink per channel.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_fail++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module ten_bit_pwm_channel_bench import tbpwm_pkg::*;;
  logic        i_mclk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [7:0]  i_avs_address = 8'h0;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0]  i_avs_byteenable = 4'hf;
  logic        i_sleep = 1'b0;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [1:0]  o_wave, o_pin_out, o_pin_oe_b;
  logic [15:0] hi0, per0, hi1, per1;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          k;
  logic [7:0]  q;
  always #5 i_mclk = ~i_mclk;
  tbpwm_top tbpwm_top_inst (.i_mclk, .i_rst_b, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
    .o_avs_waitrequest, .i_sleep, .o_wave, .o_pin_out, .o_pin_oe_b);
  tbpwm_sink sink0 (.i_mclk, .i_lvl(o_wave[0]), .o_hi(hi0), .o_per(per0));
  // Inverted channel: sink sees the active level as high
  tbpwm_sink sink1 (.i_mclk, .i_lvl(~o_wave[1]), .o_hi(hi1), .o_per(per1));
  function automatic logic [7:0] ca(input int c, input logic [3:0] o);
    return OFS_CH0 + 8'(c << CH_SHIFT) + {4'h0, o};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, d,
                     input logic [3:0] be, output logic [7:0] r);
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= be;
    i_avs_read <= !w;
    i_avs_write <= w;
    @(posedge i_mclk);
    while (o_avs_waitrequest) @(posedge i_mclk);
    r = o_avs_readdata[7:0];
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic w8(input logic [7:0] a, d);
    logic [7:0] r;
    bus(1'b1, a, d, 4'hf, r);
  endtask
  task automatic r8(input logic [7:0] a, e, input string n);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, 4'hf, r);
    `CHK(n, e, r)
  endtask
  task automatic hic(input int c, n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge i_mclk);
      if (o_wave[c] === 1'b1) h++;
    end
  endtask
  // Several periods so the sinks hold a settled measurement
  task automatic meas(input int p, h0, h1);
    repeat (4 * p) @(posedge i_mclk);
    `CHK("per0", p, per0)
    `CHK("hi0", h0, hi0)
    `CHK("per1", p, per1)
    `CHK("act1", h1, hi1)
  endtask
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge i_mclk);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    r8(OFS_PER, PER_RST, "per");
    r8(ca(0, OFS_CH_DIR), 8'h01, "dir");
    r8(ca(1, OFS_CH_CTL), 8'h00, "ctl");
    r8(ca(0, OFS_CH_DH), DUTY_RST, "dh");
    r8(8'hfc, 8'h00, "hole");
    `CHK("oe", 2'b11, o_pin_oe_b)
    bus(1'b1, OFS_PER, 8'h55, 4'he, q);
    r8(OFS_PER, PER_RST, "per_be");
    w8(OFS_PER, 8'h03);
    w8(ca(0, OFS_CH_DH), 8'h01);
    w8(ca(0, OFS_CH_DL), 8'h80);
    w8(ca(1, OFS_CH_DH), 8'h02);
    w8(ca(1, OFS_CH_DL), 8'hbf);
    r8(ca(1, OFS_CH_DL), 8'h80, "dl");
    w8(ca(0, OFS_CH_CTL), 8'h80);
    w8(ca(1, OFS_CH_CTL), 8'h90);
    w8(ca(0, OFS_CH_DIR), 8'h00);
    // Direction lands at the acknowledging edge; look one edge later
    @(posedge i_mclk);
    `CHK("oe", 2'b10, o_pin_oe_b)
    w8(OFS_TCTL, 8'h8f);
    meas(16, 6, 10);
    w8(OFS_TCTL, 8'h80);
    meas(16, 6, 10);
    w8(OFS_TCTL, 8'h90);
    meas(32, 12, 20);
    w8(OFS_TCTL, 8'h80);
    w8(ca(0, OFS_CH_DH), 8'h00);
    w8(ca(0, OFS_CH_DL), 8'h00);
    repeat (40) @(posedge i_mclk);
    hic(0, 48, k);
    `CHK("duty0", 0, k)
    w8(ca(0, OFS_CH_DH), 8'h04);
    repeat (40) @(posedge i_mclk);
    hic(0, 48, k);
    `CHK("full", 48, k)
    r8(ca(0, OFS_CH_CTL), 8'ha0, "lvl1");
    w8(ca(0, OFS_CH_DH), 8'h03);
    w8(ca(0, OFS_CH_DL), 8'hc0);
    repeat (40) @(posedge i_mclk);
    hic(0, 48, k);
    `CHK("duty15", 45, k)
    w8(ca(0, OFS_CH_CTL), 8'h00);
    repeat (40) @(posedge i_mclk);
    hic(0, 48, k);
    `CHK("off", 0, k)
    r8(ca(0, OFS_CH_CTL), 8'h00, "lvl0");
    w8(ca(0, OFS_CH_CTL), 8'h80);
    repeat (40) @(posedge i_mclk);
    i_sleep <= 1'b1;
    hic(0, 30, k);
    `CHK("frozen", 1'b1, k == 0 || k == 30)
    i_sleep <= 1'b0;
    meas(16, 15, 10);
    summarize();
  end
endmodule
